//--- shared/srcr_pkg.sv
// Shared types and constants for the safety response configuration registers.
package srcr_pkg;

  // Operating state of the device, reported by the central state machine.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RESET,
    ST_DIAGNOSTIC,
    ST_ACTIVE,
    ST_SAFE
  } srcr_dev_state_e;

  // Register select codes carried by the read and write commands.
  localparam logic [1:0] IDX_MONITOR_RESPONSE_CONFIG = 2'h0;
  localparam logic [1:0] IDX_ERROR_MONITOR_THRESHOLDS = 2'h1;
  localparam logic [1:0] IDX_WATCHDOG_FAIL_THRESHOLDS = 2'h2;
  localparam logic [1:0] IDX_REGULATOR_FAULT_RESPONSE = 2'h3;

  // Values after reset.
  localparam logic [7:0] MRC_RESET = 8'h02;
  localparam logic [7:0] EMT_RESET = 8'hF8;
  localparam logic [7:0] WFT_RESET = 8'hF5;
  localparam logic [7:0] RFR_RESET = 8'h3B;

  // Writable bits; all others are reserved and read as zero.
  localparam logic [7:0] MRC_WMASK = 8'h5F;
  localparam logic [7:0] RFR_WMASK = 8'h3B;
  // Bits of monitor_response_config reloaded on entry to RESET.
  localparam logic [7:0] MRC_RELOAD_MASK = 8'h0F;

  // Field positions in monitor_response_config.
  localparam int MRC_SPREAD_SPECTRUM = 6;
  localparam int MRC_FRAME_CHECK = 4;
  localparam int MRC_WD_SCHEME = 3;
  localparam int MRC_ESM_STYLE = 2;
  localparam int MRC_WD_RESET_SEL = 1;
  localparam int MRC_ESM_RESET_SEL = 0;

  // Threshold nibbles: reset threshold high, warning threshold low.
  localparam int TH_RESET_LSB = 4;
  localparam int TH_WARN_LSB = 0;

  // Comparator slots in the threshold bank.
  localparam int CMP_ESM_WARN = 0;
  localparam int CMP_ESM_RESET = 1;
  localparam int CMP_WD_WARN = 2;
  localparam int CMP_WD_RESET = 3;
  localparam int CMP_COUNT = 4;

  // Regulator fault event order: short, overvoltage, sink overcurrent, ground, temperature.
  localparam int FAULT_COUNT = 5;

  typedef struct packed {
    logic reached;
  } srcr_cmp_s;

  typedef struct packed {
    logic [7:0] monitor_response_config;
    logic [7:0] error_monitor_thresholds;
    logic [7:0] watchdog_fail_thresholds;
    logic [7:0] regulator_fault_response;
    srcr_dev_state_e prev_state;
    logic [7:0] rdata;
    logic wr_refused;
    logic wd_goto_reset;
    logic wd_goto_safe;
    logic watchdog_reset_fail_flag;
    logic watchdog_drive_fail_flag;
    logic enable_drive_irq_pin;
    logic esm_goto_reset;
    logic esm_goto_safe;
    logic reg_goto_off;
    logic reg_goto_safe;
  } srcr_main_s;

endpackage

//--- logic/srcr_threshold_cmp.sv
// Registered compare of a four-bit failure counter against a threshold.
`timescale 1ns/100ps
`default_nettype none
module srcr_threshold_cmp
  import srcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] count_i,
  input wire logic [3:0] threshold_i,
  output logic reached_o
);

  srcr_cmp_s q;
  srcr_cmp_s d;

  // A counter jumping past the threshold still counts as having reached it.
  always_comb begin
    d = q;
    d.reached = (count_i >= threshold_i);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reached_o = q.reached;

endmodule
`default_nettype wire

//--- logic/srcr_regs.sv
// Safety response configuration registers and the responses they select.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// [R1] Frame check bit enables SPI frame checksum.
// [R2] Scheme bit: four answers or one open-window answer.
// [R3] RESET entry reloads scheme, style, both selects.
// [R4] Style bit: low-level monitor or PWM monitor.
// [R5] Watchdog reset threshold: RESET if selected, else SAFE.
// [R6] SAFE masks watchdog reset select, value kept.
// [R7] Error monitor threshold: RESET if selected, else SAFE.
// [R8] Writes only in DIAGNOSTIC with lock clear.
// [R9] Thresholds reload on RESET; watchdog's on scheme change.
// [R10] Error reset threshold upper nibble, default 1111b.
// [R11] Error warning threshold lower nibble, ACTIVE to SAFE.
// [R12] Watchdog reset threshold sets reset-fail flag.
// [R13] Watchdog warning sets drive-fail flag, drives pin low.
// [R14] Regulator faults: OFF if selected, else SAFE.
// [R15] Reserved bits read zero, writes ignored.
module srcr_regs
  import srcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire srcr_dev_state_e dev_state_i,
  input wire logic config_lock_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [3:0] watchdog_failure_counter_i,
  input wire logic [3:0] error_monitor_failure_counter_i,
  input wire logic [FAULT_COUNT-1:0] regulator_fault_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_wr_refused_o,
  output logic frame_check_en_o,
  output logic spread_spectrum_en_o,
  output logic watchdog_answer_scheme_o,
  output logic error_pin_monitor_style_o,
  output logic watchdog_fail_reset_select_o,
  output logic error_monitor_reset_select_o,
  output logic wd_goto_reset_o,
  output logic wd_goto_safe_o,
  output logic watchdog_reset_fail_flag_o,
  output logic watchdog_drive_fail_flag_o,
  output logic enable_drive_irq_pin_o,
  output logic esm_goto_reset_o,
  output logic esm_goto_safe_o,
  output logic reg_goto_off_o,
  output logic reg_goto_safe_o
);

  srcr_main_s q;
  srcr_main_s d;
  logic [CMP_COUNT-1:0] reached;
  logic [CMP_COUNT-1:0][3:0] cmp_count;
  logic [CMP_COUNT-1:0][3:0] cmp_threshold;
  logic reset_entry;
  logic wr_ok;
  logic wd_sel_eff;
  logic diag_or_active;
  logic [FAULT_COUNT-1:0] off_select;

  function automatic logic [7:0] reg_value(input srcr_main_s s, input logic [1:0] sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      IDX_MONITOR_RESPONSE_CONFIG: v = s.monitor_response_config & MRC_WMASK; // [R15]
      IDX_ERROR_MONITOR_THRESHOLDS: v = s.error_monitor_thresholds;
      IDX_WATCHDOG_FAIL_THRESHOLDS: v = s.watchdog_fail_thresholds;
      IDX_REGULATOR_FAULT_RESPONSE: v = s.regulator_fault_response & RFR_WMASK; // [R15]
    endcase
    return v;
  endfunction

  assign cmp_count[CMP_ESM_WARN] = error_monitor_failure_counter_i;
  assign cmp_count[CMP_ESM_RESET] = error_monitor_failure_counter_i;
  assign cmp_count[CMP_WD_WARN] = watchdog_failure_counter_i;
  assign cmp_count[CMP_WD_RESET] = watchdog_failure_counter_i;
  assign cmp_threshold[CMP_ESM_WARN] = q.error_monitor_thresholds[TH_WARN_LSB +: 4]; // [R11]
  assign cmp_threshold[CMP_ESM_RESET] = q.error_monitor_thresholds[TH_RESET_LSB +: 4]; // [R10]
  assign cmp_threshold[CMP_WD_WARN] = q.watchdog_fail_thresholds[TH_WARN_LSB +: 4]; // [R13]
  assign cmp_threshold[CMP_WD_RESET] = q.watchdog_fail_thresholds[TH_RESET_LSB +: 4]; // [R12]

  genvar gi;
  generate
    for (gi = 0; gi < CMP_COUNT; gi++) begin : g_cmp
      srcr_threshold_cmp u_cmp (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .count_i(cmp_count[gi]),
        .threshold_i(cmp_threshold[gi]),
        .reached_o(reached[gi])
      );
    end
  endgenerate

  assign reset_entry = (dev_state_i == ST_RESET) && (q.prev_state != ST_RESET);
  assign wr_ok = (dev_state_i == ST_DIAGNOSTIC) && !config_lock_i; // [R8]
  assign diag_or_active = (dev_state_i == ST_DIAGNOSTIC) || (dev_state_i == ST_ACTIVE);
  // The stored select survives SAFE so that it is in force again on leaving SAFE.
  assign wd_sel_eff = q.monitor_response_config[MRC_WD_RESET_SEL]
                      && (dev_state_i != ST_SAFE); // [R6]
  // Bit 2 of the register is reserved, so the five selects are not contiguous.
  assign off_select = {q.regulator_fault_response[5:3], q.regulator_fault_response[1:0]}; // [R14]

  always_comb begin
    d = q;
    d.prev_state = dev_state_i;
    d.wr_refused = reg_wr_i && !wr_ok;
    d.rdata = reg_rd_i ? reg_value(q, reg_sel_i) : q.rdata;
    if (reg_wr_i && wr_ok) begin
      unique case (reg_sel_i)
        IDX_MONITOR_RESPONSE_CONFIG: begin
          d.monitor_response_config = reg_wdata_i & MRC_WMASK; // [R15]
          if (reg_wdata_i[MRC_WD_SCHEME] != q.monitor_response_config[MRC_WD_SCHEME]) begin
            d.watchdog_fail_thresholds = WFT_RESET; // [R9]
          end
        end
        IDX_ERROR_MONITOR_THRESHOLDS: d.error_monitor_thresholds = reg_wdata_i;
        IDX_WATCHDOG_FAIL_THRESHOLDS: d.watchdog_fail_thresholds = reg_wdata_i;
        IDX_REGULATOR_FAULT_RESPONSE: d.regulator_fault_response = reg_wdata_i & RFR_WMASK;
      endcase
    end
    if (reset_entry) begin
      d.monitor_response_config = (q.monitor_response_config & ~MRC_RELOAD_MASK)
                                  | (MRC_RESET & MRC_RELOAD_MASK); // [R3]
      d.error_monitor_thresholds = EMT_RESET; // [R9]
      d.watchdog_fail_thresholds = WFT_RESET; // [R9]
    end
    // Watchdog reset threshold routes only from DIAGNOSTIC or ACTIVE.
    d.wd_goto_reset = reached[CMP_WD_RESET] && diag_or_active && wd_sel_eff; // [R5]
    d.wd_goto_safe = reached[CMP_WD_RESET] && diag_or_active && !wd_sel_eff; // [R5]
    d.esm_goto_reset = reached[CMP_ESM_RESET] && (diag_or_active || dev_state_i == ST_SAFE)
                       && q.monitor_response_config[MRC_ESM_RESET_SEL]; // [R7] [R10]
    d.esm_goto_safe = (reached[CMP_ESM_RESET] && diag_or_active
                       && !q.monitor_response_config[MRC_ESM_RESET_SEL]) // [R7]
                      || (reached[CMP_ESM_WARN] && dev_state_i == ST_ACTIVE); // [R11]
    // Flags are sticky until the next RESET entry; a set in that cycle still wins.
    if (reset_entry) begin
      d.watchdog_reset_fail_flag = 1'b0;
      d.watchdog_drive_fail_flag = 1'b0;
    end
    if (reached[CMP_WD_RESET]) begin
      d.watchdog_reset_fail_flag = 1'b1; // [R12]
    end
    if (reached[CMP_WD_WARN]) begin
      d.watchdog_drive_fail_flag = 1'b1; // [R13]
    end
    d.enable_drive_irq_pin = !d.watchdog_drive_fail_flag; // [R13]
    d.reg_goto_off = |(regulator_fault_i & off_select); // [R14]
    d.reg_goto_safe = |(regulator_fault_i & ~off_select); // [R14]
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.monitor_response_config <= MRC_RESET;
      q.error_monitor_thresholds <= EMT_RESET; // [R9]
      q.watchdog_fail_thresholds <= WFT_RESET; // [R9]
      q.regulator_fault_response <= RFR_RESET;
      q.prev_state <= ST_OFF;
      q.enable_drive_irq_pin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign reg_wr_refused_o = q.wr_refused;
  assign frame_check_en_o = q.monitor_response_config[MRC_FRAME_CHECK]; // [R1]
  assign spread_spectrum_en_o = q.monitor_response_config[MRC_SPREAD_SPECTRUM];
  assign watchdog_answer_scheme_o = q.monitor_response_config[MRC_WD_SCHEME]; // [R2]
  assign error_pin_monitor_style_o = q.monitor_response_config[MRC_ESM_STYLE]; // [R4]
  assign watchdog_fail_reset_select_o = q.monitor_response_config[MRC_WD_RESET_SEL];
  assign error_monitor_reset_select_o = q.monitor_response_config[MRC_ESM_RESET_SEL];
  assign wd_goto_reset_o = q.wd_goto_reset;
  assign wd_goto_safe_o = q.wd_goto_safe;
  assign watchdog_reset_fail_flag_o = q.watchdog_reset_fail_flag;
  assign watchdog_drive_fail_flag_o = q.watchdog_drive_fail_flag;
  assign enable_drive_irq_pin_o = q.enable_drive_irq_pin;
  assign esm_goto_reset_o = q.esm_goto_reset;
  assign esm_goto_safe_o = q.esm_goto_safe;
  assign reg_goto_off_o = q.reg_goto_off;
  assign reg_goto_safe_o = q.reg_goto_safe;

  sequence s_accepted_write(logic [1:0] sel);
    reg_wr_i && wr_ok && reg_sel_i == sel;
  endsequence

  property p_frame_check_write;
    @(posedge clock_i) disable iff (rst_i)
      s_accepted_write(IDX_MONITOR_RESPONSE_CONFIG) ##0 (!reset_entry)
      |=> frame_check_en_o == $past(reg_wdata_i[MRC_FRAME_CHECK])
          && error_pin_monitor_style_o == $past(reg_wdata_i[MRC_ESM_STYLE]);
  endproperty
  a_frame_check_write: assert property (p_frame_check_write) else $error("config bit not stored"); // [R1] [R4]

  property p_reset_reload;
    @(posedge clock_i) disable iff (rst_i)
      reset_entry |=> watchdog_answer_scheme_o == 1'b0 && error_pin_monitor_style_o == 1'b0
                      && watchdog_fail_reset_select_o && !error_monitor_reset_select_o
                      && q.error_monitor_thresholds == EMT_RESET;
  endproperty
  a_reset_reload: assert property (p_reset_reload) else $error("RESET entry reload missed"); // [R3]

  sequence s_wd_reset_reached;
    reached[CMP_WD_RESET] && diag_or_active;
  endsequence

  property p_wd_route;
    @(posedge clock_i) disable iff (rst_i)
      s_wd_reset_reached |=> wd_goto_reset_o == $past(wd_sel_eff) && wd_goto_safe_o != wd_goto_reset_o
                             && watchdog_reset_fail_flag_o;
  endproperty
  a_wd_route: assert property (p_wd_route) else $error("watchdog route wrong"); // [R5] [R12]

  property p_safe_mask;
    @(posedge clock_i) disable iff (rst_i)
      dev_state_i == ST_SAFE |=> !wd_goto_reset_o;
  endproperty
  a_safe_mask: assert property (p_safe_mask) else $error("RESET taken from SAFE"); // [R6]

  property p_esm_route;
    @(posedge clock_i) disable iff (rst_i)
      reached[CMP_ESM_RESET] && diag_or_active
      |=> esm_goto_reset_o == $past(q.monitor_response_config[MRC_ESM_RESET_SEL])
          && (esm_goto_safe_o || esm_goto_reset_o);
  endproperty
  a_esm_route: assert property (p_esm_route) else $error("error monitor route wrong"); // [R7]

  property p_write_refused;
    @(posedge clock_i) disable iff (rst_i)
      reg_wr_i && !wr_ok && !reset_entry ##1 !$past(reset_entry)
      |-> $stable(q.regulator_fault_response) && $stable(q.error_monitor_thresholds)
          && reg_wr_refused_o;
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("locked write took effect"); // [R8]

  property p_scheme_reinit;
    @(posedge clock_i) disable iff (rst_i)
      s_accepted_write(IDX_MONITOR_RESPONSE_CONFIG)
      ##0 (reg_wdata_i[MRC_WD_SCHEME] != watchdog_answer_scheme_o)
      |=> q.watchdog_fail_thresholds == WFT_RESET;
  endproperty
  a_scheme_reinit: assert property (p_scheme_reinit) else $error("threshold not reloaded"); // [R9]

  property p_drive_pin;
    @(posedge clock_i) disable iff (rst_i)
      reached[CMP_WD_WARN] |=> watchdog_drive_fail_flag_o && !enable_drive_irq_pin_o;
  endproperty
  a_drive_pin: assert property (p_drive_pin) else $error("drive pin not low"); // [R13]

  property p_regulator;
    @(posedge clock_i) disable iff (rst_i)
      |regulator_fault_i |=> reg_goto_off_o || reg_goto_safe_o;
  endproperty
  a_regulator: assert property (p_regulator) else $error("regulator fault ignored"); // [R14]

  property p_reserved_read;
    @(posedge clock_i) disable iff (rst_i)
      reg_rd_i && reg_sel_i == IDX_MONITOR_RESPONSE_CONFIG
      |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[5] == 1'b0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bit read one"); // [R15]

endmodule
`default_nettype wire

//--- verification/srcr_host_model.sv
// Host-side model that issues register commands to the configuration block.
`timescale 1ns/100ps
`default_nettype none
module srcr_host_model (
  input wire logic clock_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [1:0] reg_sel_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'h0;
    reg_rd_o = 1'h0;
    reg_sel_o = 2'h0;
    reg_wdata_o = 8'h00;
  end

  // A command is held across exactly one rising edge. Afterwards the data bus is
  // inverted, so a stale byte can never pass for a fresh one.
  task automatic cmd(input logic wr, input logic [1:0] sel, input logic [7:0] d);
    @(negedge clock_i);
    reg_wr_o = wr;
    reg_rd_o = ~wr;
    reg_sel_o = sel;
    reg_wdata_o = d;
    @(negedge clock_i);
    reg_wr_o = 1'h0;
    reg_rd_o = 1'h0;
    reg_wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_safety_response_config_regs.sv
// Self-checking testbench for the safety response configuration registers.
`timescale 1ns/100ps
`default_nettype none
module tb_safety_response_config_regs import srcr_pkg::*; ;
  typedef struct packed {
    srcr_dev_state_e st;
    logic lock;
    logic [1:0] sel;
    logic [7:0] wd;
    logic [7:0] rd;
    logic refused;
  } srcr_row_s;

  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  srcr_dev_state_e st = ST_DIAGNOSTIC;
  logic lock = 1'h0;
  logic [3:0] wdc = 4'h0;
  logic [3:0] emc = 4'h0;
  logic [4:0] flt = 5'h00;
  logic wr, rd, refused, fce, sse, sch, sty, wsel, esel, wgr, wgs, wrf, wdf, pin;
  logic egr, egs, rgo, rgs;
  logic [1:0] sel;
  logic [7:0] wdata, rdata;
  logic [5:0] cfg_bits;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] rv [2] = '{8'h28, 8'h13};
  logic [4:0] mv [2] = '{5'h14, 5'h0B};
  srcr_row_s rows [11] = '{
    '{ST_DIAGNOSTIC, 1'h0, 2'h0, 8'hFF, 8'h5F, 1'h0},
    '{ST_DIAGNOSTIC, 1'h0, 2'h0, 8'h10, 8'h10, 1'h0},
    '{ST_DIAGNOSTIC, 1'h0, 2'h0, 8'h08, 8'h08, 1'h0},
    '{ST_DIAGNOSTIC, 1'h0, 2'h0, 8'h04, 8'h04, 1'h0},
    '{ST_DIAGNOSTIC, 1'h0, 2'h0, 8'h41, 8'h41, 1'h0},
    '{ST_DIAGNOSTIC, 1'h0, 2'h3, 8'hFF, 8'h3B, 1'h0},
    '{ST_DIAGNOSTIC, 1'h0, 2'h1, 8'h12, 8'h12, 1'h0},
    '{ST_ACTIVE, 1'h0, 2'h1, 8'h56, 8'h12, 1'h1},
    '{ST_DIAGNOSTIC, 1'h1, 2'h1, 8'h56, 8'h12, 1'h1},
    '{ST_SAFE, 1'h0, 2'h3, 8'h00, 8'h3B, 1'h1},
    '{ST_OFF, 1'h0, 2'h2, 8'h00, 8'hF5, 1'h1}
  };

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  srcr_host_model u_host (
    .clock_i(clock_i),
    .reg_wr_o(wr),
    .reg_rd_o(rd),
    .reg_sel_o(sel),
    .reg_wdata_o(wdata)
  );

  srcr_regs u_dut (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .dev_state_i(st),
    .config_lock_i(lock),
    .reg_wr_i(wr),
    .reg_rd_i(rd),
    .reg_sel_i(sel),
    .reg_wdata_i(wdata),
    .watchdog_failure_counter_i(wdc),
    .error_monitor_failure_counter_i(emc),
    .regulator_fault_i(flt),
    .reg_rdata_o(rdata),
    .reg_wr_refused_o(refused),
    .frame_check_en_o(fce),
    .spread_spectrum_en_o(sse),
    .watchdog_answer_scheme_o(sch),
    .error_pin_monitor_style_o(sty),
    .watchdog_fail_reset_select_o(wsel),
    .error_monitor_reset_select_o(esel),
    .wd_goto_reset_o(wgr),
    .wd_goto_safe_o(wgs),
    .watchdog_reset_fail_flag_o(wrf),
    .watchdog_drive_fail_flag_o(wdf),
    .enable_drive_irq_pin_o(pin),
    .esm_goto_reset_o(egr),
    .esm_goto_safe_o(egs),
    .reg_goto_off_o(rgo),
    .reg_goto_safe_o(rgs)
  );

  assign cfg_bits = {sse, fce, sch, sty, wsel, esel};

  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_resp(input string n, input logic [5:0] e, input logic [5:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic rdchk(input logic [1:0] s, input logic [7:0] e);
    u_host.cmd(1'h0, s, 8'h00);
    chk_reg("reg_rdata_o", e, rdata);
  endtask

  // Counter outputs need two edges to reach the requests; three keeps a margin.
  task automatic settle(input srcr_dev_state_e s, input logic [3:0] w, input logic [3:0] e);
    @(negedge clock_i);
    st = s;
    wdc = w;
    emc = e;
    repeat (3) @(negedge clock_i);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clock_i);
    rst_i = 1'h0;
    rdchk(2'h0, 8'h02);
    rdchk(2'h1, 8'hF8);
    rdchk(2'h2, 8'hF5);
    rdchk(2'h3, 8'h3B);
    chk_resp("pin and flags", 6'h04, {3'h0, pin, wrf, wdf});
    foreach (rows[i]) begin
      st = rows[i].st;
      lock = rows[i].lock;
      u_host.cmd(1'h1, rows[i].sel, rows[i].wd);
      chk_resp("reg_wr_refused_o", {5'h00, rows[i].refused}, {5'h00, refused});
      rdchk(rows[i].sel, rows[i].rd);
      if (rows[i].sel == 2'h0) begin
        chk_resp("reg0 outputs", {rows[i].rd[6], rows[i].rd[4:0]}, cfg_bits);
      end
    end
    st = ST_DIAGNOSTIC;
    lock = 1'h0;
    u_host.cmd(1'h1, 2'h2, 8'h34);
    u_host.cmd(1'h1, 2'h0, 8'h01);
    rdchk(2'h2, 8'h34);
    u_host.cmd(1'h1, 2'h0, 8'h09);
    rdchk(2'h2, 8'hF5);
    u_host.cmd(1'h1, 2'h0, 8'h5D);
    u_host.cmd(1'h1, 2'h2, 8'h34);
    u_host.cmd(1'h1, 2'h3, 8'h28);
    settle(ST_RESET, 4'h0, 4'h0);
    settle(ST_DIAGNOSTIC, 4'h0, 4'h0);
    rdchk(2'h0, 8'h52);
    rdchk(2'h1, 8'hF8);
    rdchk(2'h2, 8'hF5);
    rdchk(2'h3, 8'h28);
    settle(ST_ACTIVE, 4'h5, 4'h0);
    chk_resp("wd responses", 6'h04, {wgr, wgs, wrf, wdf, pin, 1'h0});
    settle(ST_ACTIVE, 4'hF, 4'h0);
    chk_resp("wd responses", 6'h2C, {wgr, wgs, wrf, wdf, pin, 1'h0});
    settle(ST_SAFE, 4'hF, 4'h0);
    chk_resp("wd reset masked", 6'h01, {4'h0, wgr, wsel});
    settle(ST_DIAGNOSTIC, 4'h0, 4'h0);
    u_host.cmd(1'h1, 2'h0, 8'h00);
    settle(ST_DIAGNOSTIC, 4'hF, 4'h0);
    chk_resp("wd requests", 6'h01, {4'h0, wgr, wgs});
    settle(ST_ACTIVE, 4'h0, 4'h8);
    chk_resp("esm requests", 6'h01, {4'h0, egr, egs});
    settle(ST_DIAGNOSTIC, 4'h0, 4'h8);
    chk_resp("esm requests", 6'h00, {4'h0, egr, egs});
    settle(ST_DIAGNOSTIC, 4'h0, 4'hF);
    chk_resp("esm requests", 6'h01, {4'h0, egr, egs});
    u_host.cmd(1'h1, 2'h0, 8'h01);
    settle(ST_DIAGNOSTIC, 4'h0, 4'hF);
    chk_resp("esm requests", 6'h02, {4'h0, egr, egs});
    settle(ST_SAFE, 4'h0, 4'hF);
    chk_resp("esm requests", 6'h02, {4'h0, egr, egs});
    settle(ST_DIAGNOSTIC, 4'h0, 4'h0);
    for (int j = 0; j < 2; j++) begin
      u_host.cmd(1'h1, 2'h3, rv[j]);
      for (int i = 0; i < 5; i++) begin
        @(negedge clock_i);
        flt = 5'h01 << i;
        repeat (2) @(negedge clock_i);
        chk_resp("fault response", {4'h0, mv[j][i], ~mv[j][i]}, {4'h0, rgo, rgs});
      end
      flt = 5'h00;
    end
    // A reset in mid-run must clear the sticky flags and reload the reset values of the selects.
    @(negedge clock_i);
    rst_i = 1'h1;
    repeat (3) @(negedge clock_i);
    rst_i = 1'h0;
    chk_resp("pin and flags", 6'h04, {3'h0, pin, wrf, wdf});
    rdchk(2'h0, 8'h02);
    rdchk(2'h3, 8'h3B);
    end_sim;
  end

  // The sequence needs well under a thousand cycles; ten thousand means a hang.
  initial begin
    #100us;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
